// ### srl_pkg.sv
// Constants and types for the storm rate limiter
// Functional notes
// - Per port class selector: broadcast, multicast or both; default both.
// - Per port limit 1 to 10 percent of bandwidth, or no limit.
// - Over the limit, every further packet of the selected class is dropped.
// - Limit is a fraction of line rate, not of current traffic.
// - No limit is default; statistics keep running without policing.
// - Five minute average of class receive percent, refreshed every 15 seconds.
// - One hour average of class receive percent, refreshed every 5 minutes.
// - 24 hour average of class receive percent, refreshed every hour.
// - Averages count ingress packets before any discard.
// - Switch wide setting applies one class and limit to every port.
// - Limiting any trunk member limits all; unlimiting one unlimits all.
package srl_pkg;
  typedef enum logic [1:0] {
    SRL_CLASS_BOTH  = 2'h0,
    SRL_CLASS_MCAST = 2'h1,
    SRL_CLASS_BCAST = 2'h2
  } srl_class_t;

  localparam logic [1:0]  SRL_CLASS_RESET  = 2'h0;
  localparam logic [3:0]  SRL_LIMIT_NONE   = 4'h0;
  localparam logic [3:0]  SRL_LIMIT_MAX    = 4'hA;
  localparam logic [3:0]  SRL_LIMIT_RESET  = 4'h0;
  localparam int          SRL_CLK_MHZ      = 125;
  localparam int          SRL_BYTES_PER_US = 125;
  // Policing interval in microseconds
  localparam int          SRL_INTERVAL_US  = 100;
  localparam int          SRL_INTERVAL_CYC = SRL_INTERVAL_US * SRL_CLK_MHZ;
  // Line bytes in one interval at 1 Gb/s
  localparam int          SRL_LINE_BYTES   = SRL_INTERVAL_US * SRL_BYTES_PER_US;
  localparam int          SRL_T5M_S        = 300;
  localparam int          SRL_T15S_S       = 15;
  localparam int          SRL_T1H_S        = 3600;
  localparam int          SRL_T24H_S       = 86400;
  localparam longint      SRL_CYC_PER_S    = 64'(SRL_CLK_MHZ) * 64'd1000000;
  localparam longint      SRL_REF15S_CYC   = 64'(SRL_T15S_S) * SRL_CYC_PER_S;
  localparam longint      SRL_REF5M_CYC    = 64'(SRL_T5M_S) * SRL_CYC_PER_S;
  localparam longint      SRL_REF1H_CYC    = 64'(SRL_T1H_S) * SRL_CYC_PER_S;
  localparam int          SRL_WIN5M_SLOTS  = SRL_T5M_S / SRL_T15S_S;
  localparam int          SRL_WIN1H_SLOTS  = SRL_T1H_S / SRL_T5M_S;
  localparam int          SRL_WIN24H_SLOTS = SRL_T24H_S / SRL_T1H_S;
  localparam int          SRL_PCT_W        = 7;
endpackage : srl_pkg

// ### srl_window_avg.sv
// Sliding window average of receive utilisation percent
module srl_window_avg
  import srl_pkg::*;
#(
  parameter longint REFRESH_CYC = SRL_REF15S_CYC,
  parameter int     SLOTS       = 20,
  parameter longint LINE_BYTES  = 64'(SRL_BYTES_PER_US) * 64'd1000000 * 64'd15
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 byte_valid,
  input  wire logic [15:0]          byte_count,
  output logic      [SRL_PCT_W-1:0] avg_pct
);
  localparam int SW = $clog2(SLOTS + 1);

  logic [63:0]          tick_reg;
  logic [63:0]          acc_reg;
  logic [SRL_PCT_W-1:0] slot_mem [SLOTS];
  logic [SW-1:0]        wr_reg;
  logic [SW+SRL_PCT_W-1:0] sum_reg;
  logic [SRL_PCT_W-1:0] avg_reg;
  wire                  refresh = (tick_reg == REFRESH_CYC - 64'd1);
  wire  [63:0]          pct_raw = (acc_reg * 64'd100) / LINE_BYTES;
  wire  [SRL_PCT_W-1:0] pct_new = (pct_raw > 64'd100) ? 7'd100 : pct_raw[SRL_PCT_W-1:0];
  wire  [SW+SRL_PCT_W-1:0] sum_next = sum_reg + (SW+SRL_PCT_W)'(pct_new)
                                     - (SW+SRL_PCT_W)'(slot_mem[wr_reg]);
  wire  [SW+SRL_PCT_W-1:0] avg_full = sum_next / (SW+SRL_PCT_W)'(SLOTS);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tick_reg <= 64'h0;
      acc_reg  <= 64'h0;
      wr_reg   <= '0;
      sum_reg  <= '0;
      avg_reg  <= '0;
    end else begin
      tick_reg <= refresh ? 64'h0 : tick_reg + 64'd1;
      if (refresh) begin
        acc_reg <= byte_valid ? 64'(byte_count) : 64'h0;
        wr_reg  <= (wr_reg == SW'(SLOTS - 1)) ? '0 : wr_reg + SW'(1);
        sum_reg <= sum_next;
        avg_reg <= avg_full[SRL_PCT_W-1:0];
      end else if (byte_valid) begin
        acc_reg <= acc_reg + 64'(byte_count);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < SLOTS; i++) slot_mem[i] <= '0;
    end else if (refresh) begin
      slot_mem[wr_reg] <= pct_new;
    end
  end

  assign avg_pct = avg_reg;

  a_avg_bounded: assert property (@(posedge clk) disable iff (!reset_n)
    avg_reg <= 7'd100) else $error("average above 100 percent");
endmodule : srl_window_avg

// ### srl_port_policer.sv
// Per interval byte policer for one port
module srl_port_policer
  import srl_pkg::*;
#(
  parameter int INTERVAL_CYC = SRL_INTERVAL_CYC,
  parameter int LINE_BYTES   = SRL_LINE_BYTES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  limit_pct,
  input  wire logic        pkt_valid,
  input  wire logic        pkt_match,
  input  wire logic [15:0] pkt_len,
  output logic             pkt_drop
);
  logic [31:0] tick_reg;
  logic [31:0] used_reg;
  logic        drop_reg;
  wire         tick_end = (tick_reg == 32'(INTERVAL_CYC - 1));
  // Allowance is a share of line rate, independent of offered load
  wire  [31:0] allow    = (32'(LINE_BYTES) * 32'(limit_pct)) / 32'd100;
  wire         limited  = (limit_pct != SRL_LIMIT_NONE);
  wire         over     = limited && (used_reg > allow);
  wire         policed  = pkt_valid && pkt_match;
  wire         drop_now = policed && over;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tick_reg <= 32'h0;
      used_reg <= 32'h0;
      drop_reg <= 1'b0;
    end else begin
      tick_reg <= tick_end ? 32'h0 : tick_reg + 32'd1;
      drop_reg <= drop_now;
      if (tick_end) begin
        used_reg <= 32'h0;
      end else if (policed && !drop_now) begin
        used_reg <= used_reg + 32'(pkt_len);
      end
    end
  end

  assign pkt_drop = drop_reg;

  a_nolimit_nodrop: assert property (@(posedge clk) disable iff (!reset_n)
    (limit_pct == SRL_LIMIT_NONE) |=> !drop_reg) else $error("drop while unlimited");
  a_drop_cause: assert property (@(posedge clk) disable iff (!reset_n)
    drop_reg |-> $past(policed) && $past(limited)) else $error("drop without cause");
endmodule : srl_port_policer

// ### srl_storm_limiter.sv
// Storm rate limiter top: per port policing and utilisation averages
module srl_storm_limiter
  import srl_pkg::*;
#(
  parameter int     PORTS        = 4,
  parameter int     TRUNKS       = 2,
  parameter int     INTERVAL_CYC = SRL_INTERVAL_CYC,
  parameter longint REF15S_CYC   = SRL_REF15S_CYC,
  parameter longint REF5M_CYC    = SRL_REF5M_CYC,
  parameter longint REF1H_CYC    = SRL_REF1H_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [2*PORTS-1:0]         port_class,
  input  wire logic [4*PORTS-1:0]         port_limit,
  input  wire logic                       global_apply,
  input  wire logic [1:0]                 global_class,
  input  wire logic [3:0]                 global_limit,
  input  wire logic [PORTS-1:0]           trunk_member,
  input  wire logic [PORTS*$clog2(TRUNKS+1)-1:0] trunk_id,
  input  wire logic [PORTS-1:0]           pkt_valid,
  input  wire logic [PORTS-1:0]           pkt_bcast,
  input  wire logic [PORTS-1:0]           pkt_mcast,
  input  wire logic [16*PORTS-1:0]        pkt_len,
  output logic      [PORTS-1:0]           pkt_drop,
  output logic      [SRL_PCT_W*PORTS-1:0] avg_5m,
  output logic      [SRL_PCT_W*PORTS-1:0] avg_1h,
  output logic      [SRL_PCT_W*PORTS-1:0] avg_24h,
  output logic      [4*PORTS-1:0]         eff_limit
);
  localparam int TW = $clog2(TRUNKS + 1);

  function automatic logic class_match(input logic [1:0] cls, input logic bc, input logic mc);
    case (cls)
      SRL_CLASS_BCAST: class_match = bc;
      SRL_CLASS_MCAST: class_match = mc;
      default:         class_match = bc || mc;
    endcase
  endfunction : class_match

  logic [2*PORTS-1:0] cls_reg;
  logic [4*PORTS-1:0] lim_reg;
  logic [4*PORTS-1:0] req_reg;
  logic [2*PORTS-1:0] cls_next;
  logic [4*PORTS-1:0] lim_req;
  logic [4*PORTS-1:0] lim_next;
  logic [4*PORTS-1:0] trunk_lim;

  // Config capture with class and limit defaults: both, no limit
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int p = 0; p < PORTS; p++) begin
        cls_reg[2*p +: 2] <= SRL_CLASS_RESET;
        lim_reg[4*p +: 4] <= SRL_LIMIT_RESET;
        req_reg[4*p +: 4] <= SRL_LIMIT_RESET;
      end
    end else begin
      cls_reg <= cls_next;
      lim_reg <= lim_next;
      req_reg <= lim_req;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_cfg
      wire [1:0] cls_sel = global_apply ? global_class : port_class[2*g +: 2];
      wire [3:0] lim_raw = global_apply ? global_limit : port_limit[4*g +: 4];
      assign cls_next[2*g +: 2] = (cls_sel == 2'h3) ? SRL_CLASS_RESET : cls_sel;
      assign lim_req[4*g +: 4]  = (lim_raw > SRL_LIMIT_MAX) ? SRL_LIMIT_MAX : lim_raw;
    end
  endgenerate

  // Trunk sharing: a member whose request changes sets the whole trunk.
  // Members otherwise hold their shared limit, so differing requests
  // inside one trunk cannot make the limit swing every cycle.
  always_comb begin
    lim_next  = lim_req;
    trunk_lim = '0;
    for (int p = 0; p < PORTS; p++) begin
      if (trunk_member[p]) begin
        lim_next[4*p +: 4] = lim_reg[4*p +: 4];
      end
    end
    for (int p = 0; p < PORTS; p++) begin
      if (trunk_member[p] && (lim_req[4*p +: 4] != req_reg[4*p +: 4])) begin
        for (int q = 0; q < PORTS; q++) begin
          if (trunk_member[q] && trunk_id[TW*q +: TW] == trunk_id[TW*p +: TW]) begin
            lim_next[4*q +: 4] = lim_req[4*p +: 4];
          end
        end
      end
    end
    for (int p = 0; p < PORTS; p++) begin
      trunk_lim[4*p +: 4] = lim_reg[4*p +: 4];
      for (int q = 0; q < PORTS; q++) begin
        if (trunk_member[p] && trunk_member[q] && trunk_id[TW*q +: TW] == trunk_id[TW*p +: TW]
            && lim_reg[4*q +: 4] == SRL_LIMIT_NONE) begin
          trunk_lim[4*p +: 4] = SRL_LIMIT_NONE;
        end
      end
    end
  end

  logic [PORTS-1:0] vld_reg;
  logic [PORTS-1:0] match_reg;
  logic [16*PORTS-1:0] len_reg;
  logic [4*PORTS-1:0]  eff_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      vld_reg   <= '0;
      match_reg <= '0;
      len_reg   <= '0;
      eff_reg   <= '0;
    end else begin
      vld_reg <= pkt_valid;
      len_reg <= pkt_len;
      eff_reg <= trunk_lim;
      for (int p = 0; p < PORTS; p++) begin
        match_reg[p] <= class_match(cls_reg[2*p +: 2], pkt_bcast[p], pkt_mcast[p]);
      end
    end
  end

  assign eff_limit = eff_reg;

  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      wire        stat_vld = vld_reg[g] && match_reg[g];
      srl_port_policer #(
        .INTERVAL_CYC (INTERVAL_CYC),
        .LINE_BYTES   (SRL_LINE_BYTES)
      ) u_pol (
        .clk       (clk),
        .reset_n   (reset_n),
        .limit_pct (trunk_lim[4*g +: 4]),
        .pkt_valid (vld_reg[g]),
        .pkt_match (match_reg[g]),
        .pkt_len   (len_reg[16*g +: 16]),
        .pkt_drop  (pkt_drop[g])
      );
      srl_window_avg #(
        .REFRESH_CYC (REF15S_CYC),
        .SLOTS       (SRL_WIN5M_SLOTS),
        .LINE_BYTES  ((REF15S_CYC * 64'(SRL_BYTES_PER_US)) / 64'(SRL_CLK_MHZ))
      ) u_a5m (
        .clk        (clk),
        .reset_n    (reset_n),
        .byte_valid (stat_vld),
        .byte_count (len_reg[16*g +: 16]),
        .avg_pct    (avg_5m[SRL_PCT_W*g +: SRL_PCT_W])
      );
      srl_window_avg #(
        .REFRESH_CYC (REF5M_CYC),
        .SLOTS       (SRL_WIN1H_SLOTS),
        .LINE_BYTES  ((REF5M_CYC * 64'(SRL_BYTES_PER_US)) / 64'(SRL_CLK_MHZ))
      ) u_a1h (
        .clk        (clk),
        .reset_n    (reset_n),
        .byte_valid (stat_vld),
        .byte_count (len_reg[16*g +: 16]),
        .avg_pct    (avg_1h[SRL_PCT_W*g +: SRL_PCT_W])
      );
      srl_window_avg #(
        .REFRESH_CYC (REF1H_CYC),
        .SLOTS       (SRL_WIN24H_SLOTS),
        .LINE_BYTES  ((REF1H_CYC * 64'(SRL_BYTES_PER_US)) / 64'(SRL_CLK_MHZ))
      ) u_a24 (
        .clk        (clk),
        .reset_n    (reset_n),
        .byte_valid (stat_vld),
        .byte_count (len_reg[16*g +: 16]),
        .avg_pct    (avg_24h[SRL_PCT_W*g +: SRL_PCT_W])
      );
    end
  endgenerate

  a_global_apply: assert property (@(posedge clk) disable iff (!reset_n)
    (global_apply && global_limit <= SRL_LIMIT_MAX && global_class != 2'h3)
      |=> (cls_reg[1:0] == $past(global_class))) else $error("global class not applied");
  a_limit_clamp: assert property (@(posedge clk) disable iff (!reset_n)
    lim_reg[3:0] <= SRL_LIMIT_MAX) else $error("limit beyond ten percent");
  a_reset_default: assert property (@(posedge clk)
    !reset_n |=> (lim_reg == '0 && cls_reg == '0)) else $error("reset defaults wrong");
endmodule : srl_storm_limiter

// ### srl_station.sv
// Station model: sources packets into the limiter ports
module srl_station (
  input  wire logic        clk,
  output logic      [3:0]  pkt_valid,
  output logic      [3:0]  pkt_bcast,
  output logic      [3:0]  pkt_mcast,
  output logic      [63:0] pkt_len
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    pkt_valid = 4'h0;
    pkt_bcast = 4'h0;
    pkt_mcast = 4'h0;
    pkt_len   = 64'h0;
  end

  // One packet per port for one cycle; kind bit0 multicast, bit1 broadcast
  task automatic send(input logic [3:0] v, input logic [7:0] k, input logic [63:0] l);
    @(negedge clk);
    pkt_valid = v;
    for (int i = 0; i < 4; i++) begin
      pkt_mcast[i] = k[2*i];
      pkt_bcast[i] = k[2*i+1];
    end
    pkt_len = l;
  endtask : send

  // Released qualifiers toggle so stale values never look valid
  task automatic idle();
    @(negedge clk);
    pkt_valid = 4'h0;
    pkt_bcast = ~pkt_bcast;
    pkt_mcast = ~pkt_mcast;
    pkt_len   = ~pkt_len;
  endtask : idle
endmodule : srl_station

// ### tb_srl_storm_limiter.sv
// Self-checking bench for the storm rate limiter
module tb_srl_storm_limiter
  import srl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk          = 1'b0;
  logic        reset_n      = 1'b0;
  logic [7:0]  port_class   = 8'h00;
  logic [15:0] port_limit   = 16'h0000;
  logic        global_apply = 1'b0;
  logic [1:0]  global_class = 2'h0;
  logic [3:0]  global_limit = 4'h0;
  logic [3:0]  trunk_member = 4'h0;
  logic [7:0]  trunk_id     = 8'h00;
  logic [3:0]  pkt_valid, pkt_bcast, pkt_mcast, pkt_drop;
  logic [63:0] pkt_len;
  logic [27:0] avg_5m, avg_1h, avg_24h;
  logic [15:0] eff_limit;
  logic [3:0]  exp_now = 4'h0, exp_d1 = 4'h0, exp_d2 = 4'h0;
  logic        chk_on  = 1'b1;
  int          used[4];
  int          miscompares  = 0;
  int          total_checks = 0;

  always #4 clk = ~clk;

  srl_station u_srl_station (.clk(clk), .pkt_valid(pkt_valid), .pkt_bcast(pkt_bcast),
                             .pkt_mcast(pkt_mcast), .pkt_len(pkt_len));

  srl_storm_limiter #(.PORTS(4), .TRUNKS(2), .REF15S_CYC(100), .REF5M_CYC(2000), .REF1H_CYC(24000))
  u_srl_storm_limiter (.clk(clk), .reset_n(reset_n), .port_class(port_class), .port_limit(port_limit),
    .global_apply(global_apply), .global_class(global_class), .global_limit(global_limit),
    .trunk_member(trunk_member), .trunk_id(trunk_id), .pkt_valid(pkt_valid), .pkt_bcast(pkt_bcast),
    .pkt_mcast(pkt_mcast), .pkt_len(pkt_len), .pkt_drop(pkt_drop), .avg_5m(avg_5m),
    .avg_1h(avg_1h), .avg_24h(avg_24h), .eff_limit(eff_limit));

  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic hit(input logic [1:0] c, input logic [1:0] k);
    return (c == 2'h1) ? k[0] : ((c == 2'h2) ? k[1] : (k != 2'h0));
  endfunction : hit

  task automatic gap(input int n);
    repeat (n) begin
      u_srl_station.idle();
      exp_now = 4'h0;
    end
  endtask : gap

  task automatic pkt(input logic [3:0] v, input logic [7:0] k, input logic [63:0] l);
    logic [1:0] c;
    logic [3:0] m;
    logic       h;
    u_srl_station.send(v, k, l);
    for (int p = 0; p < 4; p++) begin
      c = global_apply ? global_class : port_class[2*p +: 2];
      m = global_apply ? global_limit : port_limit[4*p +: 4];
      if (m > SRL_LIMIT_MAX) m = SRL_LIMIT_MAX;
      h = v[p] && hit(c, k[2*p +: 2]) && (m != SRL_LIMIT_NONE);
      exp_now[p] = h && (used[p] > SRL_LINE_BYTES * int'(m) / 100);
      if (h && !exp_now[p]) used[p] += int'(l[16*p +: 16]);
    end
  endtask : pkt

  task automatic hold_reset();
    gap(1);
    reset_n = 1'b0;
    used = '{default: 0};
  endtask : hold_reset

  task automatic release_reset();
    gap(3);
    reset_n = 1'b1;
    gap(2);
  endtask : release_reset

  // Drop pulse lands two cycles after the packet cycle
  always @(posedge clk) begin
    exp_d1 <= exp_now;
    exp_d2 <= exp_d1;
  end

  always @(negedge clk) begin
    if (chk_on) check(32'(pkt_drop), 32'(exp_d2));
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  initial begin
    logic [7:0]  k;
    logic [63:0] l;
    int          drops;
    drops = 0;
    void'($urandom(32'hE83BCFA8));
    for (int r = 0; r < 8; r++) begin
      hold_reset();
      global_apply = (r >= 6);
      global_class = 2'($urandom_range(3, 0));
      global_limit = 4'($urandom_range(10, 1));
      for (int p = 0; p < 4; p++) begin
        port_class[2*p +: 2] = (r == 0) ? 2'(p) : 2'($urandom_range(3, 0));
        port_limit[4*p +: 4] = (r == 0) ? 4'h1 : 4'($urandom_range(15, 0));
      end
      release_reset();
      for (int n = 0; n < 12; n++) begin
        for (int p = 0; p < 4; p++) begin
          k[2*p +: 2]  = 2'($urandom_range(2, 0));
          l[16*p +: 16] = 16'($urandom_range(400, 64));
        end
        pkt(r[0] ? 4'($urandom) : 4'hF, k, l);
      end
      gap(3);
    end
    hold_reset();
    global_apply = 1'b0;
    trunk_member = 4'h3;
    trunk_id     = 8'h05;
    port_limit   = 16'h7055;
    release_reset();
    gap(3);
    check(32'(eff_limit), 32'h7055);
    port_limit[7:4] = 4'h0;
    gap(4);
    check(32'(eff_limit[7:0]), 32'h00);
    port_limit[7:4] = 4'h3;
    gap(4);
    check(32'(eff_limit[7:0]), 32'h33);
    hold_reset();
    trunk_member = 4'h0;
    port_class   = 8'h90;
    port_limit   = 16'hA001;
    chk_on       = 1'b0;
    release_reset();
    repeat (24100) begin
      pkt(4'hF, 8'hAA, {4{16'd1518}});
      drops += int'(pkt_drop[0]);
    end
    gap(3);
    check(32'(drops != 0), 32'h1);
    check(32'(avg_5m[13:7]), 32'h64);
    check(32'(avg_5m[6:0]), 32'(avg_5m[13:7]));
    check(32'(avg_5m[27:21]), 32'(avg_5m[13:7]));
    check(32'(avg_5m[20:14]), 32'h0);
    check(32'(avg_1h[6:0]), 32'(avg_1h[13:7]));
    check(32'(avg_1h[20:14]), 32'h0);
    check(32'(avg_24h[6:0]), 32'(avg_24h[13:7]));
    check(32'(avg_24h[20:14]), 32'h0);
    end_sim();
  end
endmodule : tb_srl_storm_limiter
